//--- aen_pkg.sv
// Constants and carrier types for the alert enable and accumulator
// source register logic. Assumes an 8-bit register address space.
package aen_pkg;

  // Register offsets
  localparam logic [7:0]  AEN_ADDR_MASK     = 8'h49;
  localparam logic [7:0]  AEN_ADDR_ACC_ACT  = 8'h4A;

  // Widths and field positions
  localparam int          AEN_MASK_W        = 24;
  localparam int          AEN_ACC_W         = 8;
  localparam int          AEN_CHANNELS      = 4;
  localparam int          AEN_OV_LSB        = 12;
  localparam int          AEN_UV_LSB        = 8;
  localparam int          AEN_OP_LSB        = 4;
  localparam int          AEN_ACCFULL_BIT   = 3;
  localparam int          AEN_TALLY_BIT     = 2;
  localparam int          AEN_CONV_BIT      = 1;
  localparam int          AEN_UNUSED_BIT    = 0;

  // Reset values
  localparam logic [14:0] AEN_MASK_RESET    = 15'h0000;
  localparam logic [7:0]  AEN_ACC_RESET     = 8'h00;
  localparam logic [7:0]  AEN_UPPER_READ    = 8'h00;

  // Accumulator source codes
  localparam logic [1:0]  AEN_SRC_POWER     = 2'h0;
  localparam logic [1:0]  AEN_SRC_SENSE     = 2'h1;
  localparam logic [1:0]  AEN_SRC_BUS       = 2'h2;
  localparam logic [1:0]  AEN_SRC_RESERVED  = 2'h3;

  // Alert conditions and enables; bit 3 of each nibble is channel 1
  typedef struct packed {
    logic [3:0] overVolt;
    logic [3:0] underVolt;
    logic [3:0] overPower;
    logic       accumFull;
    logic       tallyFull;
    logic       convDone;
  } aen_alert_t;

  // Register access from the serial-port front end
  typedef struct packed {
    logic                  wrEn;
    logic                  rdEn;
    logic [7:0]            addr;
    logic [AEN_MASK_W-1:0] wrData;
  } aen_req_t;

  // Reserved source code reads back as power
  function automatic logic [7:0] aen_clean_src(input logic [7:0] raw);
    logic [7:0] res;
    res = raw;
    for (int i = 0; i < AEN_CHANNELS; i++) begin
      if (raw[2*i +: 2] == AEN_SRC_RESERVED) begin
        res[2*i +: 2] = AEN_SRC_POWER;
      end
    end
    return res;
  endfunction : aen_clean_src

endpackage : aen_pkg

//--- aen_alert_gate.sv
// Gates each raw alert condition with its active enable bit.
// Assumes conditions are synchronous to clk.
`timescale 1ns/10ps
module aen_alert_gate
  import aen_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // Conditions and enables
  input  wire aen_alert_t alertCond,
  input  wire aen_alert_t alertEn,
  // Gated alerts
  output aen_alert_t      alertOut
);

  aen_alert_t alert_q;
  aen_alert_t alert_d;

  genvar g;
  generate
    for (g = 0; g < $bits(aen_alert_t); g++) begin : gGate
      always_comb begin
        alert_d[g] = alertCond[g] & alertEn[g];
      end

      gate_off_a: assert property (@(posedge clk) disable iff (sys_rst)
        !alertEn[g] |=> !alertOut[g])
        else $error("alert passed while its enable was clear");

      gate_on_a: assert property (@(posedge clk) disable iff (sys_rst)
        (alertEn[g] && alertCond[g]) |=> alertOut[g])
        else $error("enabled condition did not raise its alert");
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      alert_q <= AEN_MASK_RESET;
    end else begin
      alert_q <= alert_d;
    end
  end

  assign alertOut = alert_q;

endmodule : aen_alert_gate

//--- aen_regs.sv
// Alert enable mask and active accumulator source registers.
// Assumes a serial-port front end that issues one-cycle read and write
// strobes with an 8-bit register address, and a refresh pulse from the
// command decoder.
`timescale 1ns/10ps

// Behaviour
// - Bits 15:12 enable overvoltage alerts, channels 1-4
// - Bits 11:8 enable undervoltage alerts, channels 1-4
// - Bits 7:4 enable overpower alerts, channels 1-4
// - Bit 3 enables shared accumulator full alert
// - Bit 2 enables sample tally full alert
// - Bit 1 enables conversion done alert
// - Bit 0 reads zero, writes ignored
// - Active source register mirrors configuration in force
// - Source codes power, sense, bus; reserved reads 0
// - Channel 1 at bits 7:6 down to channel 4
// - New enables take effect only on refresh
// - Alert reaches pin only when enabled
module aen_regs
  import aen_pkg::*;
(
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  // Register access
  input  wire aen_req_t              regReq,
  output logic                       regRdValid,
  output logic [AEN_MASK_W-1:0]      regRdData,
  // Refresh command and programmed source configuration
  input  wire logic                  refreshCmd,
  input  wire logic [AEN_ACC_W-1:0]  accumSrcProg,
  // Alert conditions and gated alerts
  input  wire aen_alert_t            alertCond,
  output aen_alert_t                 alertOut,
  // Active accumulator source per channel and active enable mask
  output logic [AEN_ACC_W-1:0]       accumSrcActive,
  output aen_alert_t                 alertEnActive
);

  aen_alert_t            enPend_q;
  aen_alert_t            enPend_d;
  aen_alert_t            enAct_q;
  aen_alert_t            enAct_d;
  logic [AEN_ACC_W-1:0]  accSrc_q;
  logic [AEN_ACC_W-1:0]  accSrc_d;
  logic                  rdValid_q;
  logic                  rdValid_d;
  logic [AEN_MASK_W-1:0] rdData_q;
  logic [AEN_MASK_W-1:0] rdData_d;
  logic                  wrMask;
  logic                  wrAcc;

  assign wrMask = regReq.wrEn && (regReq.addr == AEN_ADDR_MASK);
  assign wrAcc  = regReq.wrEn && (regReq.addr == AEN_ADDR_ACC_ACT);

  // Enable mask: written value waits, refresh activates it
  always_comb begin
    enPend_d = enPend_q;
    enAct_d  = enAct_q;
    if (wrMask) begin
      // Bit 0 is dropped
      enPend_d = regReq.wrData[15:1];
    end
    if (refreshCmd) begin
      enAct_d = enPend_q;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      enPend_q <= AEN_MASK_RESET;
      enAct_q  <= AEN_MASK_RESET;
    end else begin
      enPend_q <= enPend_d;
      enAct_q  <= enAct_d;
    end
  end

  // Active source: refresh loads the programmed set, which wins over
  // a direct write in the same cycle
  always_comb begin
    accSrc_d = accSrc_q;
    if (wrAcc) begin
      accSrc_d = aen_clean_src(regReq.wrData[AEN_ACC_W-1:0]);
    end
    if (refreshCmd) begin
      accSrc_d = aen_clean_src(accumSrcProg);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      accSrc_q <= AEN_ACC_RESET;
    end else begin
      accSrc_q <= accSrc_d;
    end
  end

  // Read path: answer one cycle after the strobe
  always_comb begin
    rdValid_d = regReq.rdEn;
    rdData_d  = rdData_q;
    if (regReq.rdEn) begin
      case (regReq.addr)
        AEN_ADDR_MASK: begin
          rdData_d = {AEN_UPPER_READ, enPend_q, 1'b0};
        end
        AEN_ADDR_ACC_ACT: begin
          rdData_d = {16'h0000, accSrc_q};
        end
        default: begin
          rdData_d = 24'h000000;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdValid_q <= 1'b0;
      rdData_q  <= 24'h000000;
    end else begin
      rdValid_q <= rdValid_d;
      rdData_q  <= rdData_d;
    end
  end

  assign regRdValid     = rdValid_q;
  assign regRdData      = rdData_q;
  assign accumSrcActive = accSrc_q;
  assign alertEnActive  = enAct_q;

  // Shared accumulator, tally and completion alerts are gated like the
  // per-channel ones; the active mask drives the gate
  aen_alert_gate uGate (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .alertCond (alertCond),
    .alertEn   (enAct_q),
    .alertOut  (alertOut)
  );

  // Checks
  sequence s_mask_write;
    wrMask && !refreshCmd;
  endsequence

  sequence s_acc_write;
    wrAcc && !refreshCmd;
  endsequence

  sequence s_mask_read;
    regReq.rdEn && regReq.addr == AEN_ADDR_MASK && !wrMask;
  endsequence

  sequence s_acc_read;
    regReq.rdEn && regReq.addr == AEN_ADDR_ACC_ACT;
  endsequence

  sequence s_other_read;
    regReq.rdEn && regReq.addr != AEN_ADDR_MASK &&
      regReq.addr != AEN_ADDR_ACC_ACT;
  endsequence

  sequence s_src_collide;
    wrAcc && refreshCmd;
  endsequence

  bit_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
    s_mask_read |=> !regRdData[AEN_UNUSED_BIT])
    else $error("mask bit 0 read as one");

  ov_field_a: assert property (@(posedge clk) disable iff (sys_rst)
    s_mask_read |=> regRdData[15:12] == $past(enPend_q.overVolt))
    else $error("overvoltage enables not at bits 15:12");

  uv_field_a: assert property (@(posedge clk) disable iff (sys_rst)
    s_mask_read |=> regRdData[11:8] == $past(enPend_q.underVolt))
    else $error("undervoltage enables not at bits 11:8");

  op_field_a: assert property (@(posedge clk) disable iff (sys_rst)
    s_mask_read |=> regRdData[7:1] ==
      $past({enPend_q.overPower, enPend_q.accumFull,
             enPend_q.tallyFull, enPend_q.convDone}))
    else $error("power and shared enables misplaced");

  hold_enable_a: assert property (@(posedge clk) disable iff (sys_rst)
    s_mask_write ##1 !refreshCmd |=> enAct_q == $past(enAct_q, 2))
    else $error("enable took effect without refresh");

  refresh_load_a: assert property (@(posedge clk) disable iff (sys_rst)
    s_mask_write ##1 refreshCmd |=> enAct_q == $past(regReq.wrData[15:1], 2))
    else $error("refresh did not activate written enables");

  mirror_src_a: assert property (@(posedge clk) disable iff (sys_rst)
    refreshCmd |=> accumSrcActive == aen_clean_src($past(accumSrcProg)))
    else $error("active source does not mirror refreshed set");

  no_reserved_a: assert property (@(posedge clk) disable iff (sys_rst)
    refreshCmd && accumSrcProg[7:6] == AEN_SRC_RESERVED
      |=> accumSrcActive[7:6] == AEN_SRC_POWER)
    else $error("reserved source code kept for channel 1");

  acc_read_a: assert property (@(posedge clk) disable iff (sys_rst)
    s_acc_read |=> regRdValid && regRdData == {16'h0000, $past(accSrc_q)})
    else $error("source register read mismatch");

  // Read answers
  upper_zero_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    s_mask_read |=> regRdData[23:16] == AEN_UPPER_READ)
    else $error("mask upper byte not zero");

  other_read_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    s_other_read |=> regRdValid && regRdData == 24'h000000)
    else $error("unmapped read not answered with zero");

  rd_valid_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    regReq.rdEn |=> regRdValid)
    else $error("read strobe not answered");

  no_valid_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    !regReq.rdEn |=> !regRdValid)
    else $error("read answer without a strobe");

  rd_hold_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    !regReq.rdEn |=> $stable(regRdData))
    else $error("read data moved without a read");

  // Enable mask storage
  pend_write_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    wrMask |=> enPend_q == $past(regReq.wrData[15:1]))
    else $error("mask write not stored");

  pend_hold_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    !wrMask |=> $stable(enPend_q))
    else $error("pending mask moved without a write");

  act_load_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    refreshCmd |=> enAct_q == $past(enPend_q))
    else $error("refresh did not load pending mask");

  act_hold_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    !refreshCmd |=> $stable(enAct_q))
    else $error("active mask moved without refresh");

  // Source register
  acc_write_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    s_acc_write |=> accumSrcActive ==
      aen_clean_src($past(regReq.wrData[AEN_ACC_W-1:0])))
    else $error("direct source write not stored");

  src_win_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    s_src_collide |=> accumSrcActive == aen_clean_src($past(accumSrcProg)))
    else $error("direct write beat the refresh");

  src_hold_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    !refreshCmd && !wrAcc |=> $stable(accumSrcActive))
    else $error("active source moved without cause");

  // Reserved code never stands in the active set
  for (genvar c = 0; c < AEN_CHANNELS; c++) begin : gSrcChk
    src_legal_a: assert property (
      @(posedge clk) disable iff (sys_rst)
      accumSrcActive[2*c +: 2] != AEN_SRC_RESERVED)
      else $error("reserved source code stored");
  end

  // Shared alert gating
  accfull_gate_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    1'b1 |=> alertOut.accumFull ==
      $past(alertCond.accumFull && enAct_q.accumFull))
    else $error("accumulator full alert not gated");

  tally_gate_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    1'b1 |=> alertOut.tallyFull ==
      $past(alertCond.tallyFull && enAct_q.tallyFull))
    else $error("sample tally alert not gated");

  conv_gate_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    1'b1 |=> alertOut.convDone ==
      $past(alertCond.convDone && enAct_q.convDone))
    else $error("conversion done alert not gated");

  // Reset
  rst_clear_a: assert property (
    @(posedge clk)
    sys_rst |=> !regRdValid && regRdData == 24'h000000 &&
      accumSrcActive == AEN_ACC_RESET && alertEnActive == AEN_MASK_RESET &&
      alertOut == AEN_MASK_RESET)
    else $error("outputs not cleared by reset");

endmodule : aen_regs

//--- aen_host_model.sv
// Host controller model: register strobes and refresh commands.
// Assumes the device takes requests on rising clk edges.
`timescale 1ns/10ps
module aen_host_model
  import aen_pkg::*;
(
  // Clock
  input  wire logic clk,
  // Requests to the device
  output aen_req_t  regReq,
  output logic      refreshCmd
);
  initial begin
    regReq     = '0;
    refreshCmd = 1'h0;
  end
  // One-cycle strobe; released address and data show inverted junk
  task automatic access(input logic wr, input logic [7:0] a,
                        input logic [AEN_MASK_W-1:0] d);
    @(posedge clk);
    regReq <= '{wrEn: wr, rdEn: !wr, addr: a, wrData: d};
    @(posedge clk);
    regReq <= '{wrEn: 1'h0, rdEn: 1'h0, addr: ~a, wrData: ~d};
  endtask : access
  // Written enables only apply after this command
  task automatic refresh();
    @(posedge clk);
    refreshCmd <= 1'h1;
    @(posedge clk);
    refreshCmd <= 1'h0;
  endtask : refresh
endmodule : aen_host_model

//--- alert_enable_accum_source_regs_tb_top.sv
// Self-checking bench for the alert enable and source registers.
// Assumes read answers come one cycle after the strobe edge.
`timescale 1ns/10ps
module alert_enable_accum_source_regs_tb_top;
  import aen_pkg::*;
  typedef struct {logic [7:0] a; logic [23:0] d; logic [23:0] e;} aen_row_t;
  logic                  clk;
  logic                  sysRst;
  aen_req_t              regReq;
  logic                  refreshCmd;
  logic                  regRdValid;
  logic [AEN_MASK_W-1:0] regRdData;
  logic [AEN_MASK_W-1:0] rdVal;
  logic [AEN_ACC_W-1:0]  accumSrcProg;
  logic [AEN_ACC_W-1:0]  accumSrcActive;
  aen_alert_t            alertCond;
  aen_alert_t            alertOut;
  aen_alert_t            alertEnActive;
  int                    n_mismatch;
  int                    n_tests;
  aen_row_t rows [7] = '{
    '{AEN_ADDR_MASK,    24'hFFFFFF, 24'h00FFFE},
    '{AEN_ADDR_MASK,    24'h00A5A5, 24'h00A5A4},
    '{AEN_ADDR_ACC_ACT, 24'h0000E4, 24'h000024},
    '{AEN_ADDR_ACC_ACT, 24'h000055, 24'h000055},
    '{AEN_ADDR_ACC_ACT, 24'hFFFFAA, 24'h0000AA},
    '{AEN_ADDR_ACC_ACT, 24'h00001B, 24'h000018},
    '{8'h33,            24'hFFFFFF, 24'h000000}};

  aen_host_model aen_host_model_inst (
    .clk        (clk),
    .regReq     (regReq),
    .refreshCmd (refreshCmd));
  aen_regs aen_regs_inst (
    .clk            (clk),
    .sys_rst        (sysRst),
    .regReq         (regReq),
    .regRdValid     (regRdValid),
    .regRdData      (regRdData),
    .refreshCmd     (refreshCmd),
    .accumSrcProg   (accumSrcProg),
    .alertCond      (alertCond),
    .alertOut       (alertOut),
    .accumSrcActive (accumSrcActive),
    .alertEnActive  (alertEnActive));

  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Read with a bounded wait for the answer
  task automatic rd(input logic [7:0] a);
    int i;
    aen_host_model_inst.access(1'h0, a, '0);
    #1;
    i = 0;
    while (regRdValid !== 1'h1 && i < 4) begin
      @(posedge clk);
      #1;
      i++;
    end
    if (i == 4) begin
      n_mismatch++;
      wrap_up();
    end
    rdVal = regRdData;
  endtask : rd

  task automatic chk_reset();
    rd(AEN_ADDR_MASK);
    chk(rdVal, 24'h0);
    rd(AEN_ADDR_ACC_ACT);
    chk(rdVal, 24'h0);
    chk({9'h0, alertEnActive}, 24'h0);
    chk({9'h0, alertOut}, 24'h0);
  endtask : chk_reset

  initial begin
    sysRst       = 1'h1;
    alertCond    = '0;
    accumSrcProg = 8'hE7;
    n_mismatch   = 0;
    n_tests      = 0;
    repeat (3) @(posedge clk);
    sysRst <= 1'h0;
    chk_reset();
    foreach (rows[i]) begin
      aen_host_model_inst.access(1'h1, rows[i].a, rows[i].d);
      rd(rows[i].a);
      chk(rdVal, rows[i].e);
    end
    // Pending enables stay inactive; direct source write is active
    chk({9'h0, alertEnActive}, 24'h0);
    chk({16'h0, accumSrcActive}, 24'h18);
    @(posedge clk);
    alertCond <= '1;
    repeat (2) @(posedge clk);
    #1;
    chk({9'h0, alertOut}, 24'h0);
    aen_host_model_inst.refresh();
    #1;
    chk({9'h0, alertEnActive}, 24'h0052D2);
    chk({16'h0, accumSrcActive}, 24'h24);
    @(posedge clk);
    #1;
    chk({9'h0, alertOut}, 24'h0052D2);
    // Enables cleared before limits change, no refresh yet
    aen_host_model_inst.access(1'h1, AEN_ADDR_MASK, 24'h0);
    repeat (2) @(posedge clk);
    #1;
    chk({9'h0, alertOut}, 24'h0052D2);
    // Refresh beside same-cycle writes: old pending mask, programmed set
    @(posedge clk);
    accumSrcProg <= 8'h9C;
    fork
      aen_host_model_inst.access(1'h1, AEN_ADDR_MASK, 24'h00FFFF);
      aen_host_model_inst.refresh();
    join
    #1;
    chk({9'h0, alertEnActive}, 24'h0);
    chk({16'h0, accumSrcActive}, 24'h90);
    fork
      aen_host_model_inst.access(1'h1, AEN_ADDR_ACC_ACT, 24'h55);
      aen_host_model_inst.refresh();
    join
    #1;
    chk({16'h0, accumSrcActive}, 24'h90);
    chk({9'h0, alertEnActive}, 24'h007FFF);
    // Only the completion condition remains raised
    @(posedge clk);
    alertCond <= 15'h0001;
    repeat (2) @(posedge clk);
    #1;
    chk({9'h0, alertOut}, 24'h000001);
    @(posedge clk);
    sysRst <= 1'h1;
    @(posedge clk);
    sysRst <= 1'h0;
    chk_reset();
    wrap_up();
  end
endmodule : alert_enable_accum_source_regs_tb_top
